// [src/fwg_guard.sv]
// Top of the flash rewrite guard: security state, shield window, boot swap, data flash gating.
// Assumes requests, flash array busy flags and the CPU access port all run on clk_i.
`timescale 1ns/1ps

// How it works
// RULE1 - Two 4 KB boot clusters swap boot roles
// RULE2 - Recorded swap boots from cluster 1 after reset
// RULE3 - Window start/end settable from both paths
// RULE4 - Self-programming rewrites only inside window
// RULE5 - Serial path ignores the window
// RULE6 - Boot cluster 0 lock beats window
// RULE7 - Window never limits data flash
// RULE8 - Erase lock rejects serial erase only
// RULE9 - Write lock rejects serial write only
// RULE10 - Boot cluster 0 lock blocks both paths
// RULE11 - All locks clear when shipped
// RULE12 - Locks independent, settable from both paths
// RULE13 - Erase and boot locks are permanent
// RULE14 - Write lock release: serial, others clear, blank
// RULE15 - Release takes effect at next reset
// RULE16 - Data flash erases whole 1 KB blocks
// RULE17 - Data flash accesses byte wide only
// RULE18 - No instruction fetch from data flash
// RULE19 - Code fetch continues during data rewrite
// RULE20 - No data flash access during code self-rewrite
// RULE21 - Data rewrite blocks STOP and control writes
// RULE22 - Control register resets to zero, bit 0
// RULE23 - Enable bit gates data flash access
// RULE24 - Software waits setup time after enable
// RULE25 - Refused rewrite leaves flash, reports error
module fwg_guard (
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  dev_reset_i,
	input  wire logic                  req_valid_i,
	input  fwg_pkg::fwg_req_t          req_i,
	output logic                       resp_valid_o,
	output logic                       resp_err_o,
	output fwg_pkg::fwg_cmd_t          flash_cmd_o,
	output logic                       flash_cmd_valid_o,
	input  wire logic                  cf_busy_i,
	input  wire logic                  df_busy_i,
	input  wire logic                  cf_blank_i,
	input  wire logic                  df_blank_i,
	input  wire logic                  sfr_wr_i,
	input  wire logic                  sfr_bit_i,
	input  wire logic [2:0]            sfr_bitsel_i,
	input  wire logic                  sfr_rd_i,
	input  wire logic [19:0]           sfr_addr_i,
	input  wire logic [7:0]            sfr_wdata_i,
	output logic [7:0]                 sfr_rdata_o,
	input  wire logic                  acc_valid_i,
	input  wire logic [19:0]           acc_addr_i,
	input  wire logic                  acc_fetch_i,
	input  wire logic                  acc_wide_i,
	output logic                       acc_ok_o,
	output logic                       acc_err_o,
	input  wire logic                  stop_req_i,
	output logic                       stop_grant_o,
	output logic                       boot_swap_o,
	output logic [19:0]                boot_base_o,
	output logic                       background_rewrite_exec_o,
	output fwg_pkg::fwg_sec_t          sec_o
);

	fwg_pkg::fwg_sec_t sec_reg;
	logic              rel_pend_reg;
	logic              swap_rec_reg;
	logic              swap_act_reg;
	logic [7:0]        win_start_reg;
	logic [7:0]        win_end_reg;
	logic              data_flash_access_en;
	logic              cf_self_reg;

	logic              in_boot0;
	logic              in_code;
	logic              in_data;
	logic              in_window;
	logic              acc_in_data;
	logic              allow;
	logic              is_erase;
	logic              is_write;
	logic              busy_any;
	logic              rew_ok;
	logic              release_ok;
	logic              ctrl_hit;
	logic [7:0]        req_blk;

	assign is_erase = req_valid_i && (req_i.op == fwg_pkg::FWG_OP_ERASE);
	assign is_write = req_valid_i && (req_i.op == fwg_pkg::FWG_OP_WRITE);
	assign busy_any = cf_busy_i || df_busy_i;
	assign req_blk  = req_i.addr[fwg_pkg::BLK_SHIFT +: 8];
	assign ctrl_hit = (sfr_addr_i == fwg_pkg::DFL_CTRL_ADDR);

	// Boot cluster 0 is a fixed physical range whatever the swap state
	fwg_range_chk #(.W(20)) u_boot0 (
		.val_i   (req_i.addr),
		.first_i (fwg_pkg::BOOT0_FIRST),
		.last_i  (fwg_pkg::BOOT0_LAST),
		.hit_o   (in_boot0)
	);

	fwg_range_chk #(.W(20)) u_code (
		.val_i   (req_i.addr),
		.first_i (20'h0_0000),
		.last_i  (fwg_pkg::CF_LAST),
		.hit_o   (in_code)
	);

	fwg_range_chk #(.W(20)) u_data (
		.val_i   (req_i.addr),
		.first_i (fwg_pkg::DF_FIRST),
		.last_i  (fwg_pkg::DF_LAST),
		.hit_o   (in_data)
	);

	fwg_range_chk #(.W(8)) u_window (
		.val_i   (req_blk),
		.first_i (win_start_reg),
		.last_i  (win_end_reg),
		.hit_o   (in_window)
	);

	fwg_range_chk #(.W(20)) u_acc_data (
		.val_i   (acc_addr_i),
		.first_i (fwg_pkg::DF_FIRST),
		.last_i  (fwg_pkg::DF_LAST),
		.hit_o   (acc_in_data)
	);

	fwg_perm u_perm (
		.is_erase_i    (is_erase),
		.is_write_i    (is_write),
		.from_serial_i (req_i.from_serial),
		.in_window_i   (in_window),
		.in_boot0_i    (in_boot0),
		.is_data_i     (in_data),
		.is_code_i     (in_code),
		.sec_i         (sec_reg),
		.allow_o       (allow)
	);

	// A rewrite is also refused while either array is busy; data rewrite is refused during code self-rewrite
	assign rew_ok = allow && !busy_any && !(in_data && cf_self_reg);              // [RULE25] [RULE20]

	assign release_ok = req_i.from_serial && !sec_reg.ers_prot && !sec_reg.b0_prot
		&& cf_blank_i && df_blank_i;                                          // [RULE14]

	// Security bits: power-on is the as-shipped state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sec_reg <= '0;                                                // [RULE11]
		end else begin
			if (req_valid_i && req_i.op == fwg_pkg::FWG_OP_SEC_SET) begin
				// Setting only ORs in; nothing ever clears erase or boot locks
				sec_reg.ers_prot <= sec_reg.ers_prot
					|| req_i.data[fwg_pkg::SEC_ERS_BIT];        // [RULE12] [RULE13]
				sec_reg.b0_prot  <= sec_reg.b0_prot
					|| req_i.data[fwg_pkg::SEC_B0_BIT];         // [RULE13]
				sec_reg.wr_prot  <= sec_reg.wr_prot
					|| req_i.data[fwg_pkg::SEC_WR_BIT];         // [RULE12]
			end else if (dev_reset_i && rel_pend_reg) begin
				sec_reg.wr_prot <= 1'b0;                              // [RULE15]
			end
		end
	end

	// Pending release; a new release in the reset cycle stays pending
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rel_pend_reg <= 1'b0;
		end else if (req_valid_i && req_i.op == fwg_pkg::FWG_OP_SEC_RELEASE && release_ok) begin
			rel_pend_reg <= 1'b1;                                         // [RULE14]
		end else if (dev_reset_i) begin
			rel_pend_reg <= 1'b0;
		end
	end

	// Boot swap: recorded now, acted on at the next device reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			swap_rec_reg <= 1'b0;
			swap_act_reg <= 1'b0;
		end else begin
			if (req_valid_i && req_i.op == fwg_pkg::FWG_OP_SWAP_SET) begin
				swap_rec_reg <= req_i.data[fwg_pkg::SWAP_BIT];        // [RULE1]
			end
			if (dev_reset_i) begin
				swap_act_reg <= swap_rec_reg;                         // [RULE2]
			end
		end
	end

	// Shield window, writable from either path
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			win_start_reg <= fwg_pkg::WIN_START_RST;
			win_end_reg   <= fwg_pkg::WIN_END_RST;
		end else if (req_valid_i && req_i.op == fwg_pkg::FWG_OP_WIN_SET) begin
			win_start_reg <= req_i.data[7:0];                             // [RULE3]
			win_end_reg   <= req_i.data[fwg_pkg::WIN_END_LSB +: 8];       // [RULE3]
		end
	end

	// Answer to every request, one cycle later
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			resp_valid_o <= 1'b0;
			resp_err_o   <= 1'b0;
		end else begin
			resp_valid_o <= req_valid_i;
			unique case (req_i.op)
				fwg_pkg::FWG_OP_ERASE,
				fwg_pkg::FWG_OP_WRITE:       resp_err_o <= req_valid_i && !rew_ok;     // [RULE25]
				fwg_pkg::FWG_OP_SEC_RELEASE: resp_err_o <= req_valid_i && !release_ok;
				default:                     resp_err_o <= 1'b0;
			endcase
		end
	end

	// Only permitted rewrites reach the array; data erase is aligned to its 1 KB block
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flash_cmd_valid_o <= 1'b0;
			flash_cmd_o       <= '0;
		end else begin
			flash_cmd_valid_o       <= (is_erase || is_write) && rew_ok;          // [RULE25]
			flash_cmd_o.erase       <= is_erase && rew_ok;
			flash_cmd_o.write       <= is_write && rew_ok;
			flash_cmd_o.data_region <= in_data;                                   // [RULE16]
			flash_cmd_o.addr        <= (is_erase && in_data) ?
				(req_i.addr & fwg_pkg::DF_BLK_MASK) : req_i.addr;             // [RULE16]
			flash_cmd_o.data        <= req_i.data;
		end
	end

	// Remembers whether the running code rewrite came from self-programming
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cf_self_reg <= 1'b0;
		end else if ((is_erase || is_write) && rew_ok && in_code) begin
			cf_self_reg <= !req_i.from_serial;
		end else if (!cf_busy_i && !flash_cmd_valid_o) begin
			cf_self_reg <= 1'b0;
		end
	end

	// Data flash control register: bit 0 only, locked during data rewrite
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_flash_access_en <= fwg_pkg::DFL_CTRL_RESET[fwg_pkg::DFL_EN_BIT];          // [RULE22]
		end else if (sfr_wr_i && ctrl_hit && !df_busy_i) begin                                 // [RULE21]
			if (!sfr_bit_i) begin
				data_flash_access_en <= sfr_wdata_i[fwg_pkg::DFL_EN_BIT];               // [RULE22]
			end else if (sfr_bitsel_i == fwg_pkg::DFL_EN_SEL) begin
				data_flash_access_en <= sfr_wdata_i[fwg_pkg::DFL_EN_BIT];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= (sfr_rd_i && ctrl_hit) ? {7'h00, data_flash_access_en} : 8'h00;
		end
	end

	// CPU accesses: data flash is byte-read only, enabled, and not during code self-rewrite
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_ok_o  <= 1'b0;
			acc_err_o <= 1'b0;
		end else begin
			acc_ok_o  <= acc_valid_i && (!acc_in_data || (!acc_fetch_i && !acc_wide_i
				&& data_flash_access_en && !cf_self_reg));                     // [RULE19] [RULE23]
			acc_err_o <= acc_valid_i && acc_in_data && (acc_fetch_i || acc_wide_i
				|| !data_flash_access_en || cf_self_reg);                      // [RULE17] [RULE18] [RULE20]
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stop_grant_o              <= 1'b0;
			background_rewrite_exec_o <= 1'b0;
			boot_swap_o               <= 1'b0;
			boot_base_o               <= fwg_pkg::BOOT0_FIRST;
			sec_o                     <= '0;
		end else begin
			stop_grant_o              <= stop_req_i && !df_busy_i;                          // [RULE21]
			background_rewrite_exec_o <= df_busy_i;                                         // [RULE19]
			boot_swap_o               <= swap_act_reg;
			boot_base_o               <= swap_act_reg ? fwg_pkg::BOOT1_FIRST : fwg_pkg::BOOT0_FIRST; // [RULE2]
			sec_o                     <= sec_reg;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence serial_erase_s;
		is_erase && req_i.from_serial && sec_reg.ers_prot;
	endsequence

	sequence serial_write_s;
		is_write && req_i.from_serial && sec_reg.wr_prot;
	endsequence

	sequence swap_then_reset_s;
		swap_rec_reg && dev_reset_i;
	endsequence

	serial_erase_lock_a: assert property (serial_erase_s |=> resp_err_o && !flash_cmd_valid_o) // [RULE8]
		else $error("serial erase passed erase lock");
	serial_write_lock_a: assert property (serial_write_s |=> resp_err_o && !flash_cmd_o.write) // [RULE9]
		else $error("serial write passed write lock");
	boot0_lock_a: assert property ((is_erase || is_write) && in_boot0 && sec_reg.b0_prot // [RULE10]
		|=> resp_err_o && !flash_cmd_valid_o)
		else $error("boot cluster 0 rewrite not refused");
	self_window_a: assert property ((is_erase || is_write) && !req_i.from_serial && in_code // [RULE4]
		&& !in_window |=> resp_err_o)
		else $error("self rewrite outside window accepted");
	lock_permanent_a: assert property (sec_reg.ers_prot && sec_reg.b0_prot // [RULE13]
		|=> sec_reg.ers_prot [*2] ##0 sec_reg.b0_prot)
		else $error("permanent lock cleared");
	release_wait_a: assert property (sec_reg.wr_prot && !dev_reset_i |=> sec_reg.wr_prot) // [RULE15]
		else $error("write lock cleared without reset");
	ctrl_busy_lock_a: assert property (df_busy_i && sfr_wr_i && ctrl_hit // [RULE21]
		|=> $stable(data_flash_access_en))
		else $error("control register changed during data rewrite");
	stop_refuse_a: assert property (df_busy_i |=> !stop_grant_o) // [RULE21]
		else $error("STOP granted during data rewrite");
	df_fetch_a: assert property (acc_valid_i && acc_in_data && acc_fetch_i // [RULE18]
		|=> acc_err_o && !acc_ok_o)
		else $error("fetch from data flash granted");
	boot_swap_a: assert property (swap_then_reset_s |-> ##2 boot_base_o == fwg_pkg::BOOT1_FIRST) // [RULE2]
		else $error("swap not applied after reset");

endmodule

// [src/fwg_pkg.sv]
// Package for the flash rewrite guard: address map, field layout, reset values, request types.
// Assumes a 20-bit CPU address space and one system clock for every user of these types.
package fwg_pkg;

	localparam int          ADDR_W         = 20;
	localparam int          BLK_W          = 8;

	// Data flash control register and its only live field
	localparam logic [19:0] DFL_CTRL_ADDR  = 20'hF_0090;
	localparam logic [7:0]  DFL_CTRL_RESET = 8'h00;
	localparam int          DFL_EN_BIT     = 0;
	localparam logic [2:0]  DFL_EN_SEL     = 3'h0;

	// Boot clusters, 4 KB each
	localparam logic [19:0] BOOT0_FIRST    = 20'h0_0000;
	localparam logic [19:0] BOOT0_LAST     = 20'h0_0FFF;
	localparam logic [19:0] BOOT1_FIRST    = 20'h0_1000;

	// Flash regions and block geometry
	localparam logic [19:0] CF_LAST        = 20'h1_FFFF;
	localparam logic [19:0] DF_FIRST       = 20'hF_1000;
	localparam logic [19:0] DF_LAST        = 20'hF_17FF;
	localparam int          BLK_SHIFT      = 10;
	localparam logic [19:0] DF_BLK_MASK    = 20'hF_FC00;

	// Shield window after power-on: whole code flash open
	localparam logic [7:0]  WIN_START_RST  = 8'h00;
	localparam logic [7:0]  WIN_END_RST    = 8'h7F;

	// Request data field positions for security set, window set and swap set
	localparam int          SEC_ERS_BIT    = 0;
	localparam int          SEC_WR_BIT     = 1;
	localparam int          SEC_B0_BIT     = 2;
	localparam int          WIN_END_LSB    = 8;
	localparam int          SWAP_BIT       = 0;

	typedef enum logic [2:0] {
		FWG_OP_ERASE,
		FWG_OP_WRITE,
		FWG_OP_SEC_SET,
		FWG_OP_SEC_RELEASE,
		FWG_OP_WIN_SET,
		FWG_OP_SWAP_SET
	} fwg_op_t;

	typedef struct packed {
		logic           from_serial;
		fwg_op_t        op;
		logic [19:0]    addr;
		logic [15:0]    data;
	} fwg_req_t;

	typedef struct packed {
		logic           erase;
		logic           write;
		logic           data_region;
		logic [19:0]    addr;
		logic [15:0]    data;
	} fwg_cmd_t;

	typedef struct packed {
		logic           ers_prot;
		logic           wr_prot;
		logic           b0_prot;
	} fwg_sec_t;

endpackage

// [src/fwg_range_chk.sv]
// Inclusive range compare of a value against a lower and upper bound.
// Assumes the caller keeps first <= last; an inverted range matches nothing.
`timescale 1ns/1ps
module fwg_range_chk #(
	parameter int W = 20
) (
	input  wire logic [W-1:0] val_i,
	input  wire logic [W-1:0] first_i,
	input  wire logic [W-1:0] last_i,
	output logic              hit_o
);

	assign hit_o = (val_i >= first_i) && (val_i <= last_i);

endmodule

// [src/fwg_perm.sv]
// Permission decision for one erase or write request.
// Assumes region and window hits are already decoded by the caller.
`timescale 1ns/1ps
module fwg_perm (
	input  wire logic             is_erase_i,
	input  wire logic             is_write_i,
	input  wire logic             from_serial_i,
	input  wire logic             in_window_i,
	input  wire logic             in_boot0_i,
	input  wire logic             is_data_i,
	input  wire logic             is_code_i,
	input  fwg_pkg::fwg_sec_t     sec_i,
	output logic                  allow_o
);

	logic deny_boot0;
	logic deny_window;
	logic deny_serial;

	// Boot cluster 0 lock beats any window that covers it
	assign deny_boot0  = sec_i.b0_prot && in_boot0_i && is_code_i;             // [RULE10] [RULE6]
	// Window limits only self-programming and only code flash
	assign deny_window = !from_serial_i && is_code_i && !in_window_i;          // [RULE4] [RULE5] [RULE7]
	// Erase and write locks act on the serial path only
	assign deny_serial = from_serial_i &&
		((is_erase_i && sec_i.ers_prot) || (is_write_i && sec_i.wr_prot)); // [RULE8] [RULE9]

	assign allow_o = (is_erase_i || is_write_i) && (is_code_i || is_data_i)
		&& !deny_boot0 && !deny_window && !deny_serial;

endmodule

// [dv/fwg_flash_model.sv]
// Flash array model for the guard: busy span after each issued erase or write, blank tracking.
// Assumes commands arrive from the guard on the same clock and reset.
`timescale 1ns/1ps
module fwg_flash_model (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         slow_i,
	input  wire logic         cmd_valid_i,
	input  fwg_pkg::fwg_cmd_t cmd_i,
	output logic              cf_busy_o,
	output logic              df_busy_o,
	output logic              cf_blank_o,
	output logic              df_blank_o
);
	logic [3:0] cnt_reg;
	logic       df_reg;
	logic       cf_blank_reg;
	logic       df_blank_reg;

	// Busy span after each command, short or long on request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_reg <= 4'h0;
			df_reg  <= 1'b0;
		end else if (cmd_valid_i) begin
			cnt_reg <= slow_i ? 4'hF : 4'h1;
			df_reg  <= cmd_i.data_region;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	// A write leaves its array no longer blank
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cf_blank_reg <= 1'b1;
			df_blank_reg <= 1'b1;
		end else if (cmd_valid_i && cmd_i.write) begin
			cf_blank_reg <= cf_blank_reg & cmd_i.data_region;
			df_blank_reg <= df_blank_reg & ~cmd_i.data_region;
		end
	end

	assign cf_busy_o  = (cnt_reg != 4'h0) && !df_reg;
	assign df_busy_o  = (cnt_reg != 4'h0) && df_reg;
	assign cf_blank_o = cf_blank_reg;
	assign df_blank_o = df_blank_reg;
endmodule

// [dv/testbench.sv]
// Self-checking bench for the flash rewrite guard with an array model on its far side.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
module testbench;
	localparam int              SETUP_CYC = 50;
	localparam fwg_pkg::fwg_op_t OP_ER  = fwg_pkg::FWG_OP_ERASE;
	localparam fwg_pkg::fwg_op_t OP_WR  = fwg_pkg::FWG_OP_WRITE;
	localparam fwg_pkg::fwg_op_t OP_SEC = fwg_pkg::FWG_OP_SEC_SET;
	localparam fwg_pkg::fwg_op_t OP_REL = fwg_pkg::FWG_OP_SEC_RELEASE;
	localparam fwg_pkg::fwg_op_t OP_WIN = fwg_pkg::FWG_OP_WIN_SET;
	localparam fwg_pkg::fwg_op_t OP_SWP = fwg_pkg::FWG_OP_SWAP_SET;
	logic clk, rstn, dev_rst, rv, slow, sw, sb, sr, av, af, aw, stp;
	logic resp_v, resp_e, cmd_v, cfb, dfb, cfk, dfk, ok, er, grant, swp, bg_exec;
	logic [2:0]  sel;
	logic [19:0] sa, aa, base;
	logic [7:0]  wd, rd, ws, we;
	logic [31:0] rs;
	fwg_pkg::fwg_req_t rq;
	fwg_pkg::fwg_cmd_t cmd, last_cmd;
	fwg_pkg::fwg_sec_t sec;
	int fails, checks;

	fwg_guard i_dut (.clk_i(clk), .rstn_i(rstn), .dev_reset_i(dev_rst), .req_valid_i(rv), .req_i(rq),
		.resp_valid_o(resp_v), .resp_err_o(resp_e), .flash_cmd_o(cmd), .flash_cmd_valid_o(cmd_v),
		.cf_busy_i(cfb), .df_busy_i(dfb), .cf_blank_i(cfk), .df_blank_i(dfk), .sfr_wr_i(sw), .sfr_bit_i(sb),
		.sfr_bitsel_i(sel), .sfr_rd_i(sr), .sfr_addr_i(sa), .sfr_wdata_i(wd), .sfr_rdata_o(rd),
		.acc_valid_i(av), .acc_addr_i(aa), .acc_fetch_i(af), .acc_wide_i(aw), .acc_ok_o(ok), .acc_err_o(er),
		.stop_req_i(stp), .stop_grant_o(grant), .boot_swap_o(swp), .boot_base_o(base),
		.background_rewrite_exec_o(bg_exec), .sec_o(sec));
	fwg_flash_model i_flash (.clk_i(clk), .rstn_i(rstn), .slow_i(slow), .cmd_valid_i(cmd_v), .cmd_i(cmd),
		.cf_busy_o(cfb), .df_busy_o(dfb), .cf_blank_o(cfk), .df_blank_o(dfk));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// Refusal while only the write lock is set
	function automatic logic refuse(input logic s, input logic ers_op, input logic [19:0] a);
		return (!s && (a[17:10] < ws || a[17:10] > we)) || (s && !ers_op);
	endfunction

	// Lets the array model raise busy first, then waits for it to clear
	task automatic idle();
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 40 && (cfb || dfb); i++) begin
			@(posedge clk);
			#1;
		end
		if (cfb || dfb) fails++;
	endtask

	task automatic req(input logic s, input fwg_pkg::fwg_op_t o, input logic [19:0] a, input logic [15:0] d,
		input logic e);
		logic rw;
		logic [17:0] kind;
		rw = (o == OP_ER) || (o == OP_WR);
		@(posedge clk);
		rv <= 1'b1;
		rq <= '{s, o, a, d};
		@(posedge clk);
		rv <= 1'b0;
		#1;
		last_cmd = cmd;
		chk("resp_valid", 32'(resp_v), 32'h0000_0001);
		chk("resp_err", 32'(resp_e), 32'(e));
		chk("cmd_valid", 32'(cmd_v), 32'(rw & ~e));
		kind = {last_cmd.erase, last_cmd.write, last_cmd.data};
		if (rw && !e) chk("cmd_kind", 32'(kind), 32'({o == OP_ER, o == OP_WR, d}));
		if (!slow) idle();
	endtask

	task automatic acc(input logic [19:0] a, input logic f, input logic w, input logic e);
		@(posedge clk);
		av <= 1'b1;
		aa <= a;
		af <= f;
		aw <= w;
		@(posedge clk);
		av <= 1'b0;
		#1;
		chk("acc_ok_err", 32'({ok, er}), 32'({~e, e}));
	endtask

	task automatic sfr_w(input logic b, input logic [7:0] d);
		@(posedge clk);
		sw <= 1'b1;
		sb <= b;
		sel <= d[7:5];
		sa <= fwg_pkg::DFL_CTRL_ADDR;
		wd <= d;
		@(posedge clk);
		sw <= 1'b0;
	endtask

	task automatic sfr_r(input logic [19:0] a, input logic [7:0] x);
		@(posedge clk);
		sr <= 1'b1;
		sa <= a;
		@(posedge clk);
		sr <= 1'b0;
		#1;
		chk("sfr_rdata", 32'(rd), 32'(x));
	endtask

	task automatic pulse_dev_reset();
		@(posedge clk);
		dev_rst <= 1'b1;
		@(posedge clk);
		dev_rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict();
	end

	initial begin
		{rstn, dev_rst, rv, slow, sw, sb, sr, av, af, aw, stp} = '0;
		sel = 3'h0;
		sa = '0;
		aa = '0;
		wd = '0;
		rq = '0;
		fails = 0;
		checks = 0;
		rs = 32'h0000_87d5;
		ws = 8'h00;
		we = 8'h7F;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		chk("sec", 32'(sec), 32'h0000_0000);
		chk("boot_base", 32'(base), 32'h0000_0000);
		sfr_r(fwg_pkg::DFL_CTRL_ADDR, 8'h00);
		req(1'b1, OP_SEC, 20'h0_0000, 16'h0002, 1'b0);
		chk("sec", 32'(sec), 32'h0000_0002);
		req(1'b1, OP_WR, 20'h0_2000, 16'h1234, 1'b1);
		req(1'b1, OP_ER, 20'h0_2000, 16'h0000, 1'b0);
		req(1'b0, OP_REL, 20'h0_0000, 16'h0000, 1'b1);
		req(1'b1, OP_REL, 20'h0_0000, 16'h0000, 1'b0);
		chk("sec", 32'(sec), 32'h0000_0002);
		pulse_dev_reset();
		chk("sec", 32'(sec), 32'h0000_0000);
		req(1'b0, OP_SEC, 20'h0_0000, 16'h0002, 1'b0);
		req(1'b0, OP_WR, 20'h0_2000, 16'h1234, 1'b0);
		req(1'b1, OP_REL, 20'h0_0000, 16'h0000, 1'b1);
		req(1'b0, OP_WIN, 20'h0_0000, 16'h0604, 1'b0);
		ws = 8'h04;
		we = 8'h06;
		req(1'b0, OP_ER, 20'h0_0C00, 16'h0000, 1'b1);
		req(1'b0, OP_ER, 20'h0_1000, 16'h0000, 1'b0);
		req(1'b0, OP_WR, 20'h0_1BFF, 16'h00A5, 1'b0);
		req(1'b0, OP_WR, 20'h0_1C00, 16'h00A5, 1'b1);
		req(1'b1, OP_ER, 20'h0_0C00, 16'h0000, 1'b0);
		for (int i = 0; i < 24; i++) begin
			rs = xs(rs);
			ws = {4'h0, rs[3:0]};
			we = ws + {4'h0, rs[7:4]};
			req(rs[8], OP_WIN, 20'h0_0000, {we, ws}, 1'b0);
			rs = xs(rs);
			req(rs[16], rs[15] ? OP_WR : OP_ER, {5'h00, rs[14:0]}, rs[31:16],
				refuse(rs[16], !rs[15], {5'h00, rs[14:0]}));
		end
		req(1'b1, OP_WIN, 20'h0_0000, 16'h0600, 1'b0);
		req(1'b0, OP_ER, 20'h0_0000, 16'h0000, 1'b0);
		req(1'b1, OP_SEC, 20'h0_0000, 16'h0005, 1'b0);
		chk("sec", 32'(sec), 32'h0000_0007);
		req(1'b0, OP_ER, 20'h0_0000, 16'h0000, 1'b1);
		req(1'b0, OP_WR, 20'h0_0400, 16'h0011, 1'b1);
		req(1'b0, OP_ER, 20'h0_1400, 16'h0000, 1'b0);
		req(1'b1, OP_ER, 20'h0_1400, 16'h0000, 1'b1);
		req(1'b1, OP_REL, 20'h0_0000, 16'h0000, 1'b1);
		pulse_dev_reset();
		chk("sec", 32'(sec), 32'h0000_0007);
		sfr_w(1'b0, 8'hFF);
		sfr_r(fwg_pkg::DFL_CTRL_ADDR, 8'h01);
		sfr_r(20'hF_0091, 8'h00);
		repeat (SETUP_CYC) @(posedge clk);
		acc(20'hF_1000, 1'b0, 1'b0, 1'b0);
		acc(20'hF_1000, 1'b0, 1'b1, 1'b1);
		acc(20'hF_1000, 1'b1, 1'b0, 1'b1);
		req(1'b0, OP_ER, 20'hF_1234, 16'h0000, 1'b0);
		chk("cmd_addr", 32'(last_cmd.addr), 32'h000F_1000);
		chk("cmd_region", 32'(last_cmd.data_region), 32'h0000_0001);
		slow = 1'b1;
		req(1'b0, OP_WR, 20'hF_1010, 16'h005A, 1'b0);
		@(posedge clk);
		stp <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("stop_grant", 32'(grant), 32'h0000_0000);
		chk("bg_exec", 32'(bg_exec), 32'h0000_0001);
		acc(20'h0_0100, 1'b1, 1'b0, 1'b0);
		sfr_w(1'b0, 8'h00);
		sfr_r(fwg_pkg::DFL_CTRL_ADDR, 8'h01);
		req(1'b0, OP_ER, 20'h0_1400, 16'h0000, 1'b1);
		idle();
		@(posedge clk);
		stp <= 1'b0;
		#1;
		chk("stop_grant", 32'(grant), 32'h0000_0001);
		req(1'b0, OP_WR, 20'h0_1400, 16'h0033, 1'b0);
		acc(20'hF_1000, 1'b0, 1'b0, 1'b1);
		slow = 1'b0;
		idle();
		acc(20'hF_1000, 1'b0, 1'b0, 1'b0);
		sfr_w(1'b1, 8'h00);
		acc(20'hF_1000, 1'b0, 1'b0, 1'b1);
		sfr_w(1'b1, 8'h21);
		sfr_r(fwg_pkg::DFL_CTRL_ADDR, 8'h00);
		req(1'b0, OP_SWP, 20'h0_0000, 16'h0001, 1'b0);
		chk("boot_base", 32'(base), 32'h0000_0000);
		pulse_dev_reset();
		chk("boot_swap", 32'(swp), 32'h0000_0001);
		chk("boot_base", 32'(base), 32'h0000_1000);
		give_verdict();
	end
endmodule
